/* osc_ctrl_pkg.sv */
// osc_ctrl_pkg: register map, field positions and timing counts for
// the oscillator-ready interrupt and locked-loop control block.
// assumes a 32-bit AXI4-Lite register bus with byte addresses.
package osc_ctrl_pkg;
  // ****************************************************************
  // register byte offsets
  // ****************************************************************
  localparam logic [7:0] ENABLE_CLEAR_OFS = 8'h00;
  localparam logic [7:0] IRQ_ENABLE_SET_OFS = 8'h04;
  localparam logic [7:0] IRQ_STATUS_OFS = 8'h08;
  localparam logic [7:0] CLOCK_STATUS_OFS = 8'h0c;
  localparam logic [7:0] LOOP_MULTIPLY_OFS = 8'h2c;
  localparam logic [7:0] LOOP_SYNC_REQUEST_OFS = 8'h30;
  localparam logic [7:0] SUPPLY_BROWNOUT_OFS = 8'h34;
  localparam logic [7:0] LOOP_VALUE_OFS = 8'h38;
  localparam int ADDR_WIDTH = 8;
  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int FAST_CRYSTAL_BIT = 0;
  localparam int SLOW_CRYSTAL_BIT = 1;
  localparam int SLOW_RC_BIT = 2;
  localparam int FAST_RC_BIT = 3;
  localparam int LOOP_READY_BIT = 4;
  localparam int EVENT_COUNT = 5;
  localparam int OSC_COUNT = 4;
  localparam int COARSE_LOCK_BIT = 5;
  localparam int FINE_LOCK_BIT = 6;
  localparam int READ_REQUEST_BIT = 7;
  localparam int MULTIPLY_WIDTH = 16;
  // implemented bits of the brown-out control word
  localparam logic [31:0] BROWNOUT_MASK = 32'h003ff35e;
  // ****************************************************************
  // reset values and answers
  // ****************************************************************
  localparam logic [EVENT_COUNT-1:0] ENABLE_RESET = 5'h00;
  localparam logic [MULTIPLY_WIDTH-1:0] MULTIPLY_RESET = 16'h0000;
  localparam logic [31:0] BROWNOUT_RESET = 32'h00000000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ****************************************************************
  // timing: cycles from a read request to a refreshed loop value
  // ****************************************************************
  localparam int SYNC_CYCLES = 4;
  localparam int SYNC_COUNT_WIDTH = 3;
endpackage

/* osc_ready_irq_and_frequency_locked_loop_control.sv */
// osc_ready_irq_and_frequency_locked_loop_control: oscillator-ready interrupt enables,
// interrupt status and request, locked-loop multiply factor with its
// side effects, loop value read request and brown-out control word.
// assumes AXI4-Lite from a master on the same clock; oscillator ready
// and lock indications arrive asynchronously; loop value is on clock.
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module osc_ready_irq_and_frequency_locked_loop_control #(
  parameter int FINE_WIDTH = 10
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [osc_ctrl_pkg::ADDR_WIDTH-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [osc_ctrl_pkg::ADDR_WIDTH-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [osc_ctrl_pkg::OSC_COUNT-1:0] oscReadyPins,
  input wire logic [1:0] lockPins,
  input wire logic [31:0] loopValue,
  output logic irq,
  output logic [osc_ctrl_pkg::MULTIPLY_WIDTH-1:0] loopMultiplyFactor,
  output logic [FINE_WIDTH-1:0] fineCalibration,
  output logic locksLost,
  output logic [31:0] brownoutControl
);
  import osc_ctrl_pkg::*;

  localparam logic [FINE_WIDTH-1:0] FINE_MID =
    FINE_WIDTH'(1) << (FINE_WIDTH - 1);

  if (FINE_WIDTH < 2 || FINE_WIDTH > 16) begin : gBadFine
    $error("FINE_WIDTH must lie between 2 and 16");
  end

  // ****************************************************************
  // helper functions
  // ****************************************************************
  function automatic logic [31:0] laneMask(input logic [3:0] s);
    laneMask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  function automatic logic isMapped(input logic [ADDR_WIDTH-1:0] a);
    case (a)
      ENABLE_CLEAR_OFS, IRQ_ENABLE_SET_OFS, IRQ_STATUS_OFS,
      CLOCK_STATUS_OFS, LOOP_MULTIPLY_OFS, LOOP_SYNC_REQUEST_OFS,
      SUPPLY_BROWNOUT_OFS, LOOP_VALUE_OFS: isMapped = 1'b1;
      default: isMapped = 1'b0;
    endcase
  endfunction

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  localparam int SYNC_BITS = OSC_COUNT + 2;
  logic [SYNC_BITS-1:0] syncA_r, syncB_r, syncC_r, filt_r, filtOld_r;
  logic [OSC_COUNT-1:0] oscReady, oscRise;
  logic [1:0] lockLevel;

  always_ff @(posedge clock) begin
    if (reset) begin
      syncA_r <= '0;
      syncB_r <= '0;
      syncC_r <= '0;
      filt_r <= '0;
      filtOld_r <= '0;
    end else begin
      syncA_r <= {lockPins, oscReadyPins};
      syncB_r <= syncA_r;
      syncC_r <= syncB_r;
      // a change counts once the second and third stages agree
      filt_r <= (syncB_r & syncC_r) | (filt_r & (syncB_r | syncC_r));
      filtOld_r <= filt_r;
    end
  end

  assign oscReady = filt_r[OSC_COUNT-1:0];
  assign oscRise = filt_r[OSC_COUNT-1:0] & ~filtOld_r[OSC_COUNT-1:0];
  assign lockLevel = filt_r[SYNC_BITS-1:OSC_COUNT];

  // ****************************************************************
  // AXI4-Lite write channel
  // ****************************************************************
  logic awHave_r, wHave_r;
  logic [ADDR_WIDTH-1:0] wAddr_r;
  logic [31:0] wData_r;
  logic [3:0] wStrb_r;
  logic doWrite;
  logic [31:0] wEff;
  logic [31:0] wMask;

  assign awready = !awHave_r && !bvalid;
  assign wready = !wHave_r && !bvalid;
  assign doWrite = awHave_r && wHave_r && !bvalid;
  assign wMask = laneMask(wStrb_r);
  assign wEff = wData_r & wMask;

  always_ff @(posedge clock) begin
    if (reset) begin
      awHave_r <= 1'b0;
      wHave_r <= 1'b0;
      wAddr_r <= '0;
      wData_r <= '0;
      wStrb_r <= '0;
    end else if (doWrite) begin
      awHave_r <= 1'b0;
      wHave_r <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        awHave_r <= 1'b1;
        wAddr_r <= awaddr;
      end
      if (wvalid && wready) begin
        wHave_r <= 1'b1;
        wData_r <= wdata;
        wStrb_r <= wstrb;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (doWrite) begin
      bvalid <= 1'b1;
      bresp <= isMapped(wAddr_r) ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  logic wrClear, wrSet, wrStatus, wrMul, wrSync, wrBrown;
  assign wrClear = doWrite && wAddr_r == ENABLE_CLEAR_OFS;
  assign wrSet = doWrite && wAddr_r == IRQ_ENABLE_SET_OFS;
  assign wrStatus = doWrite && wAddr_r == IRQ_STATUS_OFS;
  assign wrMul = doWrite && wAddr_r == LOOP_MULTIPLY_OFS &&
    (wStrb_r[1] || wStrb_r[0]);
  assign wrSync = doWrite && wAddr_r == LOOP_SYNC_REQUEST_OFS &&
    wEff[READ_REQUEST_BIT];
  assign wrBrown = doWrite && wAddr_r == SUPPLY_BROWNOUT_OFS;

  // ****************************************************************
  // interrupt enables, status and request
  // ****************************************************************
  logic [EVENT_COUNT-1:0] enable_r, status_r, events;
  logic loopReadyEvent;

  always_ff @(posedge clock) begin
    if (reset) begin
      enable_r <= ENABLE_RESET;
    end else if (wrClear) begin
      // only ones clear; zero bits keep their enable
      enable_r <= enable_r & ~wEff[EVENT_COUNT-1:0];
    end else if (wrSet) begin
      enable_r <= enable_r | wEff[EVENT_COUNT-1:0];
    end
  end

  assign events = {loopReadyEvent, oscRise};

  always_ff @(posedge clock) begin
    if (reset) begin
      status_r <= '0;
    end else begin
      // a new event wins over a clear in the same cycle
      status_r <= (status_r & ~(wrStatus ? wEff[EVENT_COUNT-1:0] : '0))
        | events;
    end
  end

  assign irq = |(status_r & enable_r);

  // ****************************************************************
  // multiply factor, locks and fine calibration
  // ****************************************************************
  logic [1:0] lock_r;

  always_ff @(posedge clock) begin
    if (reset) begin
      loopMultiplyFactor <= MULTIPLY_RESET;
    end else if (wrMul) begin
      // lanes not strobed keep their old bits
      loopMultiplyFactor <= (loopMultiplyFactor & ~wMask[15:0]) |
        wEff[15:0];
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      lock_r <= 2'h0;
      fineCalibration <= FINE_MID;
      locksLost <= 1'b0;
    end else begin
      locksLost <= wrMul;
      if (wrMul) begin
        lock_r <= 2'h0;
        fineCalibration <= FINE_MID;
      end else begin
        lock_r <= lock_r | lockLevel;
      end
    end
  end

  // ****************************************************************
  // loop value read request
  // ****************************************************************
  logic [31:0] loopValue_r;
  logic loopReady_r, syncBusy_r;
  logic [SYNC_COUNT_WIDTH-1:0] syncCount_r;

  assign loopReadyEvent = syncBusy_r && syncCount_r == '0;

  always_ff @(posedge clock) begin
    if (reset) begin
      syncBusy_r <= 1'b0;
      syncCount_r <= '0;
    end else if (wrSync) begin
      syncBusy_r <= 1'b1;
      syncCount_r <= SYNC_COUNT_WIDTH'(SYNC_CYCLES - 1);
    end else if (syncBusy_r) begin
      if (syncCount_r == '0) begin
        syncBusy_r <= 1'b0;
      end else begin
        syncCount_r <= syncCount_r - 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      loopValue_r <= '0;
      loopReady_r <= 1'b0;
    end else if (wrSync) begin
      loopReady_r <= 1'b0;
    end else if (loopReadyEvent) begin
      loopValue_r <= loopValue;
      loopReady_r <= 1'b1;
    end
  end

  // ****************************************************************
  // brown-out control word
  // ****************************************************************
  always_ff @(posedge clock) begin
    if (reset) begin
      brownoutControl <= BROWNOUT_RESET;
    end else if (wrBrown) begin
      brownoutControl <= ((brownoutControl & ~wMask) | wEff)
        & BROWNOUT_MASK;
    end
  end

  // ****************************************************************
  // AXI4-Lite read channel
  // ****************************************************************
  logic [31:0] readWord;

  always_comb begin
    readWord = 32'h00000000;
    case (araddr)
      ENABLE_CLEAR_OFS: readWord[EVENT_COUNT-1:0] = enable_r;
      IRQ_ENABLE_SET_OFS: readWord[EVENT_COUNT-1:0] = enable_r;
      IRQ_STATUS_OFS: readWord[EVENT_COUNT-1:0] = status_r;
      CLOCK_STATUS_OFS: readWord[FINE_LOCK_BIT:0] =
        {lock_r, loopReady_r, oscReady};
      LOOP_MULTIPLY_OFS: readWord[15:0] = loopMultiplyFactor;
      SUPPLY_BROWNOUT_OFS: readWord = brownoutControl;
      LOOP_VALUE_OFS: readWord = loopValue_r;
      default: readWord = 32'h00000000;
    endcase
  end

  assign arready = !rvalid;

  always_ff @(posedge clock) begin
    if (reset) begin
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata <= readWord;
      rresp <= isMapped(araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  clear_one_drops_a: assert property (
    wrClear && wEff[FAST_RC_BIT] |=> !enable_r[FAST_RC_BIT])
    else $error("fast rc enable survived a clear");
  clear_bits_drop_a: assert property (
    wrClear && wEff[SLOW_RC_BIT] |=> !enable_r[SLOW_RC_BIT])
    else $error("slow rc enable survived a clear");
  clear_crystal_a: assert property (
    wrClear && wEff[SLOW_CRYSTAL_BIT] |=> !enable_r[SLOW_CRYSTAL_BIT])
    else $error("slow crystal enable survived a clear");
  clear_fast_xtal_a: assert property (
    wrClear && wEff[FAST_CRYSTAL_BIT] |=> !enable_r[FAST_CRYSTAL_BIT])
    else $error("fast crystal enable survived a clear");
  clear_zero_keeps_a: assert property (
    wrClear |=> (enable_r | $past(wEff[EVENT_COUNT-1:0])) ==
      ($past(enable_r) | $past(wEff[EVENT_COUNT-1:0])))
    else $error("zero write changed an enable");
  irq_follows_a: assert property (
    ##1 $rose(irq) |-> $past(|events) || $past(wrSet))
    else $error("interrupt rose without event or enable");
  mul_write_side_a: assert property (
    wrMul |=> lock_r == 2'h0 && fineCalibration == FINE_MID && locksLost)
    else $error("multiply write kept a lock or fine value");
  mul_value_a: assert property (
    wrMul && wStrb_r[1:0] == 2'h3 |=> loopMultiplyFactor ==
      $past(wData_r[15:0]))
    else $error("multiply factor not stored");
  ready_after_req_a: assert property (
    wrSync ##1 (!wrSync) [*4] |=> loopReady_r &&
      loopValue_r == $past(loopValue))
    else $error("loop ready not set after request");
  ready_drops_a: assert property (
    wrSync |=> !loopReady_r)
    else $error("loop ready kept across a new request");
  clear_read_a: assert property (
    arvalid && arready && araddr == ENABLE_CLEAR_OFS |=>
      rdata[EVENT_COUNT-1:0] == enable_r || $past(doWrite))
    else $error("clear register read differs from enables");

  irq_seen_c: cover property (irq ##1 wrClear ##1 !irq);
  mul_write_c: cover property (lock_r != 2'h0 ##1 wrMul);
  sync_done_c: cover property (wrSync ##[1:8] loopReadyEvent);
endmodule // osc_ready_irq_and_frequency_locked_loop_control

/* osc_ready_irq_and_frequency_locked_loop_control_tb_top.sv */
// osc_ready_irq_and_frequency_locked_loop_control_tb_top: self-checking bench for the
// oscillator-ready interrupt and locked-loop control block.
// assumes the block's package is compiled first; one clock, no model.
`timescale 1ns/1ps
module osc_ready_irq_and_frequency_locked_loop_control_tb_top;
  import osc_ctrl_pkg::*;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic [7:0] awaddr = 8'h00;
  logic awvalid = 1'b0;
  logic awready;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'h0;
  logic wvalid = 1'b0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready = 1'b0;
  logic [7:0] araddr = 8'h00;
  logic arvalid = 1'b0;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready = 1'b0;
  logic [3:0] oscReadyPins = 4'h0;
  logic [1:0] lockPins = 2'h0;
  logic [31:0] loopValue = 32'h00000000;
  logic irq;
  logic [15:0] loopMultiplyFactor;
  logic [9:0] fineCalibration;
  logic locksLost;
  logic [31:0] brownoutControl;
  int errorCnt = 0;
  int checks = 0;
  int cycles = 0;
  int lostSeen = 0;

  always #10 clock = ~clock;

  osc_ready_irq_and_frequency_locked_loop_control #(.FINE_WIDTH(10)) dut (
    .clock(clock), .reset(reset),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .oscReadyPins(oscReadyPins), .lockPins(lockPins),
    .loopValue(loopValue), .irq(irq),
    .loopMultiplyFactor(loopMultiplyFactor),
    .fineCalibration(fineCalibration), .locksLost(locksLost),
    .brownoutControl(brownoutControl)
  );

  // ****************************************************************
  // helpers
  // ****************************************************************
  always @(posedge clock) begin
    cycles++;
    if (locksLost === 1'b1) lostSeen++;
    if (cycles == 6000) begin
      errorCnt++;
      complete_run();
    end
  end

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      errorCnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                           input logic [3:0] s, output logic [1:0] r);
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clock);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] r);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clock);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_write(a, d, 4'hf, r);
    check("write response", {30'h0, RESP_OKAY}, {30'h0, r});
  endtask

  task automatic rd_check(input string what, input logic [7:0] a,
                          input logic [31:0] m, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axi_read(a, d, r);
    check(what, exp, d & m);
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic test_reset;
    rd_check("enables", ENABLE_CLEAR_OFS, 32'hffffffff, 32'h0);
    rd_check("multiply", LOOP_MULTIPLY_OFS, 32'hffffffff, 32'h0);
    check("fine", 32'h200, {22'h0, fineCalibration});
    check("irq", 32'h0, {31'h0, irq});
    $display("test reset done");
  endtask

  task automatic test_enable_clear;
    logic [31:0] e;
    e = 32'h1f;
    wr(IRQ_ENABLE_SET_OFS, 32'h1f);
    wr(ENABLE_CLEAR_OFS, 32'h0);
    rd_check("clear zero", IRQ_ENABLE_SET_OFS, 32'h1f, e);
    for (int i = 0; i < OSC_COUNT; i++) begin
      e = e & ~(32'h1 << i);
      wr(ENABLE_CLEAR_OFS, 32'h1 << i);
      rd_check("clear bit", IRQ_ENABLE_SET_OFS, 32'h1f, e);
      rd_check("clear read", ENABLE_CLEAR_OFS, 32'h1f, e);
      rd_check("read again", ENABLE_CLEAR_OFS, 32'h1f, e);
    end
    wr(ENABLE_CLEAR_OFS, 32'h1f);
    $display("test enable clear done");
  endtask

  task automatic test_irq;
    wr(IRQ_ENABLE_SET_OFS, 32'h1);
    settle(1);
    check("irq idle", 32'h0, {31'h0, irq});
    @(posedge clock);
    oscReadyPins <= 4'hf;
    settle(8);
    check("irq ready", 32'h1, {31'h0, irq});
    rd_check("status", IRQ_STATUS_OFS, 32'h0f, 32'h0f);
    rd_check("levels", CLOCK_STATUS_OFS, 32'h0f, 32'h0f);
    wr(ENABLE_CLEAR_OFS, 32'h1);
    settle(1);
    check("irq masked", 32'h0, {31'h0, irq});
    wr(IRQ_STATUS_OFS, 32'h0f);
    wr(IRQ_ENABLE_SET_OFS, 32'h0f);
    settle(1);
    check("irq cleared", 32'h0, {31'h0, irq});
    wr(ENABLE_CLEAR_OFS, 32'h0f);
    $display("test irq done");
  endtask

  task automatic test_multiply;
    logic [1:0] r;
    lockPins <= 2'h3;
    settle(8);
    @(posedge clock);
    lockPins <= 2'h0;
    settle(8);
    rd_check("locks held", CLOCK_STATUS_OFS, 32'h60, 32'h60);
    lostSeen = 0;
    axi_write(LOOP_MULTIPLY_OFS, 32'h00001234, 4'h3, r);
    settle(2);
    check("factor", 32'h1234, {16'h0, loopMultiplyFactor});
    check("fine mid", 32'h200, {22'h0, fineCalibration});
    check("lost pulses", 32'h1, lostSeen);
    rd_check("locks gone", CLOCK_STATUS_OFS, 32'h60, 32'h0);
    rd_check("factor rd", LOOP_MULTIPLY_OFS, 32'hffff, 32'h1234);
    axi_write(LOOP_MULTIPLY_OFS, 32'h0000ab00, 4'h2, r);
    rd_check("factor lane", LOOP_MULTIPLY_OFS, 32'hffff, 32'hab34);
    $display("test multiply done");
  endtask

  task automatic test_read_request;
    logic [31:0] d;
    logic [1:0] r;
    int n;
    loopValue <= 32'h5a5ac3c3;
    wr(LOOP_SYNC_REQUEST_OFS, 32'h80);
    n = 0;
    do begin
      axi_read(CLOCK_STATUS_OFS, d, r);
      n++;
    end while (d[LOOP_READY_BIT] !== 1'b1 && n < 20);
    check("ready flag", 32'h1, {31'h0, d[LOOP_READY_BIT]});
    rd_check("loop value", LOOP_VALUE_OFS, 32'hffffffff, 32'h5a5ac3c3);
    rd_check("ready event", IRQ_STATUS_OFS, 32'h10, 32'h10);
    $display("test read request done");
  endtask

  task automatic test_map;
    logic [31:0] d;
    logic [1:0] r;
    axi_write(8'h40, 32'hffffffff, 4'hf, r);
    check("bad write", {30'h0, RESP_SLVERR}, {30'h0, r});
    axi_read(8'h40, d, r);
    check("bad read", {30'h0, RESP_SLVERR}, {30'h0, r});
    check("bad data", 32'h0, d);
    wr(SUPPLY_BROWNOUT_OFS, 32'hffffffff);
    rd_check("brownout", SUPPLY_BROWNOUT_OFS, 32'hffffffff, BROWNOUT_MASK);
    check("brownout pin", BROWNOUT_MASK, brownoutControl);
    rd_check("sync reads 0", LOOP_SYNC_REQUEST_OFS, 32'hffffffff, 32'h0);
    $display("test map done");
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, errorCnt);
    if (errorCnt == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    test_reset();
    test_enable_clear();
    test_irq();
    test_multiply();
    test_read_request();
    test_map();
    complete_run();
  end
endmodule // osc_ready_irq_and_frequency_locked_loop_control_tb_top
